// file: logic/imt_pkg.sv
// package: constants, types and events of the i2c transaction sequencer
// assumes a 40 MHz system clock and a separate link clock for the bit engine
//
// Function
// RULE_01: address byte bit eight gives direction
// RULE_02: pattern one: address, first, second, stop
// RULE_03: pattern two: address, second buffer, stop
// RULE_04: no buffers: address only, then stop
// RULE_05: plain read: address with read, clock in
// RULE_06: acknowledge every read byte but last
// RULE_07: last read byte gets nack, then stop
// RULE_08: write first buffer, restart, read phase
// RULE_09: events for start, address, data, nack, arbitration, stop
// RULE_10: no new transaction before own stop
// RULE_11: recovery: conditions, sda release, pulse, reset
// RULE_12: completion reported only after stop; code reports done without stop on lost arbitration and non-stop ops
// RULE_13: standard 100 kbps and fast 400 kbps
// RULE_14: sensed sda mismatch flags lost arbitration
// RULE_15: slave nack: stop and report nack
// RULE_16: slave acknowledges and drives read data
package imt_pkg;
   localparam int unsigned CLK_PERIOD_PS  = 25000;
   localparam int unsigned LINK_PERIOD_PS = 30000;
   localparam int unsigned STD_RATE_KBPS  = 100;
   localparam int unsigned FAST_RATE_KBPS = 400;
   // quarter bit time in link cycles, rounded up so the rate stays at or below max
   localparam int unsigned QTR_STD  =
      (1000000000 / (STD_RATE_KBPS * 4) + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int unsigned QTR_FAST =
      (1000000000 / (FAST_RATE_KBPS * 4) + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int unsigned QCNT_W_DEF = 8;
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ  = 1'h1;
   localparam logic ACK_BIT   = 1'h0;
   localparam logic NACK_BIT  = 1'h1;
   // link-to-system toggle indices; 5..0 line up with imt_evt_type
   localparam int unsigned EV_STOP  = 0;
   localparam int unsigned EV_ARB   = 1;
   localparam int unsigned EV_NACK  = 2;
   localparam int unsigned EV_DATA  = 3;
   localparam int unsigned EV_ADDR  = 4;
   localparam int unsigned EV_START = 5;
   localparam int unsigned EV_DONE  = 6;
   localparam int unsigned EV_RX    = 7;
   localparam int unsigned EV_FETCH = 8;
   localparam int unsigned L2C_W    = 9;
   // system-to-link toggle indices
   localparam int unsigned CT_CMD = 0;
   localparam int unsigned CT_ACK = 1;
   localparam int unsigned C2L_W  = 2;

   typedef enum logic [2:0] {
      OP_XFER, OP_START, OP_RESTART, OP_STOP, OP_SDA_REL, OP_SCL_PULSE, OP_RESET
   } imt_op_type;

   typedef enum logic [1:0] {RES_OK, RES_NACK, RES_ARB} imt_res_type;

   typedef enum logic [2:0] {
      S_IDLE, S_START, S_RESTART, S_BYTE_W, S_BYTE_R, S_FETCH, S_STOP, S_PULSE
   } imt_lstate_type;

   typedef struct packed {
      imt_op_type  op;
      logic        fast;
      logic [6:0]  addr;
      logic [7:0]  len1;
      logic [7:0]  len2;
      logic [7:0]  rd_len;
   } imt_cmd_type;

   typedef struct packed {
      logic start;
      logic addr;
      logic data;
      logic nack;
      logic arb;
      logic stop;
   } imt_evt_type;
endpackage

// file: logic/imt_tsync.sv
// toggle synchroniser: a vector of toggles from another domain into pulses
// assumes each toggle changes at most once per three destination clocks
`timescale 1ns/1ps
`default_nettype none
module imt_tsync
#(
   parameter int unsigned W = 1
)
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] tgl_in,
   output logic      [W-1:0] pulse
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   if (W < 1)
   begin : g_bad_w
      $error("toggle width must be at least one");
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end
      else
      begin
         s1_ff <= tgl_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign pulse = s2_ff ^ s3_ff;
endmodule // imt_tsync
`default_nettype wire

// file: logic/imt_sequencer.sv
// i2c master transaction sequencer: command side on clock, bit engine on link_clk
// assumes open-drain pins resolved outside; pins are asynchronous to both clocks
`timescale 1ns/1ps
`default_nettype none
module imt_sequencer
   import imt_pkg::*;
#(
   parameter int unsigned QCNT_W = QCNT_W_DEF
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        link_clk,
   input  wire logic        cmd_valid,
   input  wire imt_cmd_type cmd,
   output logic             cmd_ready,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   output logic             tx_ready,
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   output logic             done,
   output imt_res_type      result,
   output logic             busy,
   output imt_evt_type      evt,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_n,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n
);
   if (QTR_STD > (1 << QCNT_W))
   begin : g_bad_qcnt
      $error("quarter counter too narrow");
   end

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic              busy_ff, nxt_busy;
   imt_cmd_type       cmd_ff, nxt_cmd;
   logic              req_ff, nxt_req;
   logic              want_ff, nxt_want;
   logic [7:0]        txb_ff, nxt_txb;
   logic              ack_ff, nxt_ack;
   logic [7:0]        rxd_ff, nxt_rxd;
   logic              rxv_ff, nxt_rxv;
   logic              done_ff, nxt_done;
   imt_res_type       resu_ff, nxt_resu;
   imt_evt_type       evt_ff, nxt_evt;
   logic [L2C_W-1:0]  l2c_p;
   logic [C2L_W-1:0]  c2l_p;

   imt_lstate_type    st_ff, nxt_st;
   logic [1:0]        ph_ff, nxt_ph;
   logic [QCNT_W-1:0] q_ff, nxt_q;
   logic [3:0]        bit_ff, nxt_bit;
   logic [7:0]        sh_ff, nxt_sh;
   logic              smp_ff, nxt_smp;
   imt_cmd_type       e_ff, nxt_e;
   logic              dir_ff, nxt_dir;
   logic              adr_ff, nxt_adr;
   logic              scl_drv_ff, nxt_scl;
   logic              sda_drv_ff, nxt_sda;
   imt_res_type       res_ff, nxt_res;
   logic [L2C_W-1:0]  tgl_ff, nxt_tgl;
   logic [7:0]        rxb_ff, nxt_rxb;
   logic              scl_s1_ff, scl_s_ff, sda_s1_ff, sda_s_ff;
   logic              tick, stretch, step, lose, fin, go_next;
   logic [QCNT_W-1:0] qtr;

   // ---------------------------------------------------------------
   // crossings
   // ---------------------------------------------------------------
   imt_tsync #(.W(L2C_W)) u_l2c
   (
      .clock  (clock),
      .rst_n  (rst_n),
      .tgl_in (tgl_ff),
      .pulse  (l2c_p)
   );

   imt_tsync #(.W(C2L_W)) u_c2l
   (
      .clock  (link_clk),
      .rst_n  (rst_n),
      .tgl_in ({ack_ff, req_ff}),
      .pulse  (c2l_p)
   );

   // ---------------------------------------------------------------
   // system side: command, byte hand-off, events
   // ---------------------------------------------------------------
   assign cmd_ready = !busy_ff || (cmd.op == OP_RESET); // [RULE_10]
   assign tx_ready  = want_ff;

   always_comb
   begin
      nxt_busy = busy_ff;
      nxt_cmd  = cmd_ff;
      nxt_req  = req_ff;
      nxt_want = want_ff;
      nxt_txb  = txb_ff;
      nxt_ack  = ack_ff;
      nxt_rxd  = rxd_ff;
      nxt_rxv  = 1'h0;
      nxt_done = 1'h0;
      nxt_resu = resu_ff;
      nxt_evt  = imt_evt_type'(l2c_p[EV_START:EV_STOP]); // [RULE_09]
      if (l2c_p[EV_FETCH])
         nxt_want = 1'h1;
      if (want_ff && tx_valid)
      begin
         nxt_txb  = tx_data;
         nxt_want = 1'h0;
         nxt_ack  = !ack_ff;
      end
      if (l2c_p[EV_RX])
      begin
         nxt_rxd = rxb_ff;
         nxt_rxv = 1'h1;
      end
      if (l2c_p[EV_DONE])
      begin
         nxt_busy = 1'h0;
         nxt_want = 1'h0;
         nxt_done = 1'h1;
         nxt_resu = res_ff;
      end
      if (cmd_valid && cmd_ready)
      begin
         nxt_cmd  = cmd;
         nxt_busy = 1'h1;
         nxt_req  = !req_ff;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_ff <= 1'h0;
         cmd_ff  <= '0;
         req_ff  <= 1'h0;
         want_ff <= 1'h0;
         txb_ff  <= 8'h00;
         ack_ff  <= 1'h0;
         rxd_ff  <= 8'h00;
         rxv_ff  <= 1'h0;
         done_ff <= 1'h0;
         resu_ff <= RES_OK;
         evt_ff  <= '0;
      end
      else
      begin
         busy_ff <= nxt_busy;
         cmd_ff  <= nxt_cmd;
         req_ff  <= nxt_req;
         want_ff <= nxt_want;
         txb_ff  <= nxt_txb;
         ack_ff  <= nxt_ack;
         rxd_ff  <= nxt_rxd;
         rxv_ff  <= nxt_rxv;
         done_ff <= nxt_done;
         resu_ff <= nxt_resu;
         evt_ff  <= nxt_evt;
      end
   end

   assign busy     = busy_ff;
   assign rx_valid = rxv_ff;
   assign rx_data  = rxd_ff;
   assign done     = done_ff;
   assign result   = resu_ff;
   assign evt      = evt_ff;

   // ---------------------------------------------------------------
   // link side: pin synchronisers and bit engine
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_s1_ff <= 1'h1;
         scl_s_ff  <= 1'h1;
         sda_s1_ff <= 1'h1;
         sda_s_ff  <= 1'h1;
      end
      else
      begin
         scl_s1_ff <= scl_in;
         scl_s_ff  <= scl_s1_ff;
         sda_s1_ff <= sda_in;
         sda_s_ff  <= sda_s1_ff;
      end
   end

   // quarter bit length by selected rate
   assign qtr = e_ff.fast ? QCNT_W'(QTR_FAST - 1) : QCNT_W'(QTR_STD - 1); // [RULE_13]
   assign tick = (q_ff == '0);
   // slave holding scl low stretches the high phase
   assign stretch = (st_ff != S_IDLE) && (st_ff != S_START) && (st_ff != S_FETCH)
                    && !scl_drv_ff && !scl_s_ff;
   assign step = tick && !stretch && (st_ff != S_IDLE) && (st_ff != S_FETCH);

   always_comb
   begin
      nxt_st  = st_ff;
      nxt_ph  = ph_ff;
      nxt_bit = bit_ff;
      nxt_sh  = sh_ff;
      nxt_smp = smp_ff;
      nxt_e   = e_ff;
      nxt_dir = dir_ff;
      nxt_adr = adr_ff;
      nxt_res = res_ff;
      nxt_tgl = tgl_ff;
      nxt_rxb = rxb_ff;
      nxt_scl = scl_drv_ff;
      nxt_sda = sda_drv_ff;
      lose    = 1'h0;
      fin     = 1'h0;
      go_next = 1'h0;
      nxt_q   = (tick || stretch || st_ff == S_IDLE || st_ff == S_FETCH) ? qtr : q_ff - 1'h1;
      // line drive (1 pulls low) by state and phase
      case (st_ff)
         S_START:
         begin
            nxt_scl = ph_ff[1];
            nxt_sda = (ph_ff != 2'h0);
         end
         S_RESTART:
         begin
            nxt_scl = (ph_ff == 2'h0) || (ph_ff == 2'h3);
            nxt_sda = ph_ff[1];
         end
         S_STOP:
         begin
            nxt_scl = (ph_ff == 2'h0);
            nxt_sda = !ph_ff[1];
         end
         S_BYTE_W:
         begin
            nxt_scl = (ph_ff == 2'h0) || (ph_ff == 2'h3);
            nxt_sda = bit_ff[3] ? 1'h0 : !sh_ff[7];
         end
         S_BYTE_R:
         begin
            nxt_scl = (ph_ff == 2'h0) || (ph_ff == 2'h3);
            nxt_sda = bit_ff[3] ? (e_ff.rd_len != 8'h01) : 1'h0; // [RULE_06] [RULE_07]
         end
         S_PULSE:
         begin
            nxt_scl = (ph_ff == 2'h0) || (ph_ff == 2'h3); // [RULE_11]
            nxt_sda = 1'h0;
         end
         S_FETCH: nxt_scl = 1'h1;
         default: ;
      endcase
      if (step)
      begin
         nxt_ph = ph_ff + 2'h1;
         case (st_ff)
            S_START:
            begin
               // bus already busy or another master ahead
               if (ph_ff == 2'h0 && (!sda_s_ff || !scl_s_ff))
                  lose = 1'h1;
               else if (ph_ff == 2'h3)
               begin
                  nxt_tgl[EV_START] = !tgl_ff[EV_START]; // [RULE_09]
                  if (e_ff.op == OP_XFER)
                  begin
                     nxt_sh  = {e_ff.addr, dir_ff}; // [RULE_01]
                     nxt_adr = 1'h1;
                     nxt_bit = 4'h0;
                     nxt_st  = S_BYTE_W;
                  end
                  else
                     fin = 1'h1;
               end
            end
            S_RESTART:
            begin
               if (ph_ff == 2'h3)
               begin
                  nxt_tgl[EV_START] = !tgl_ff[EV_START];
                  if (e_ff.op == OP_XFER)
                  begin
                     nxt_dir = DIR_READ;
                     nxt_sh  = {e_ff.addr, DIR_READ}; // [RULE_08]
                     nxt_adr = 1'h1;
                     nxt_bit = 4'h0;
                     nxt_st  = S_BYTE_W;
                  end
                  else
                     fin = 1'h1;
               end
            end
            S_BYTE_W, S_BYTE_R:
            begin
               if (ph_ff == 2'h2)
               begin
                  nxt_smp = sda_s_ff;
                  if (st_ff == S_BYTE_W && !bit_ff[3] && sh_ff[7] && !sda_s_ff)
                     lose = 1'h1; // [RULE_14]
               end
               else if (ph_ff == 2'h3)
               begin
                  nxt_bit = bit_ff + 4'h1;
                  if (!bit_ff[3])
                     nxt_sh = {sh_ff[6:0], smp_ff}; // [RULE_05]
                  else if (st_ff == S_BYTE_W)
                  begin
                     if (adr_ff)
                        nxt_tgl[EV_ADDR] = !tgl_ff[EV_ADDR];
                     else
                        nxt_tgl[EV_DATA] = !tgl_ff[EV_DATA];
                     if (smp_ff == NACK_BIT)
                     begin
                        nxt_res = RES_NACK; // [RULE_15]
                        nxt_tgl[EV_NACK] = !tgl_ff[EV_NACK];
                        nxt_st = S_STOP;
                     end
                     else
                        go_next = 1'h1;
                  end
                  else
                  begin
                     nxt_rxb = sh_ff;
                     nxt_tgl[EV_RX]   = !tgl_ff[EV_RX];
                     nxt_tgl[EV_DATA] = !tgl_ff[EV_DATA];
                     nxt_e.rd_len = e_ff.rd_len - 8'h01;
                     nxt_bit = 4'h0;
                     if (e_ff.rd_len == 8'h01)
                        nxt_st = S_STOP; // [RULE_07]
                  end
               end
            end
            S_STOP:
            begin
               if (ph_ff == 2'h3)
               begin
                  nxt_tgl[EV_STOP] = !tgl_ff[EV_STOP];
                  fin = 1'h1; // [RULE_12]
               end
            end
            S_PULSE: fin = (ph_ff == 2'h3);
            default: ;
         endcase
      end
      // next phase of the transaction after an acknowledged byte
      if (go_next)
      begin
         nxt_adr = 1'h0;
         nxt_bit = 4'h0;
         if (adr_ff && dir_ff)
            nxt_st = S_BYTE_R; // [RULE_05]
         else if (e_ff.len1 != 8'h00)
         begin
            nxt_e.len1 = e_ff.len1 - 8'h01; // [RULE_02]
            nxt_tgl[EV_FETCH] = !tgl_ff[EV_FETCH];
            nxt_st = S_FETCH;
         end
         else if (e_ff.len2 != 8'h00 && e_ff.rd_len == 8'h00)
         begin
            nxt_e.len2 = e_ff.len2 - 8'h01; // [RULE_03]
            nxt_tgl[EV_FETCH] = !tgl_ff[EV_FETCH];
            nxt_st = S_FETCH;
         end
         else if (e_ff.rd_len != 8'h00)
            nxt_st = S_RESTART; // [RULE_08]
         else
            nxt_st = S_STOP; // [RULE_04]
      end
      if (st_ff == S_FETCH && c2l_p[CT_ACK])
      begin
         nxt_sh  = txb_ff;
         nxt_bit = 4'h0;
         nxt_ph  = 2'h0;
         nxt_st  = S_BYTE_W;
      end
      if (lose)
      begin
         nxt_st  = S_IDLE;
         nxt_scl = 1'h0;
         nxt_sda = 1'h0;
         nxt_res = RES_ARB;
         nxt_tgl[EV_ARB] = !tgl_ff[EV_ARB]; // [RULE_09]
         fin = 1'h1;
      end
      // new command; reset is taken in any state
      if (c2l_p[CT_CMD] && (st_ff == S_IDLE || cmd_ff.op == OP_RESET))
      begin
         nxt_e   = cmd_ff;
         nxt_res = RES_OK;
         nxt_ph  = 2'h0;
         nxt_q   = cmd_ff.fast ? QCNT_W'(QTR_FAST - 1) : QCNT_W'(QTR_STD - 1);
         nxt_dir = (cmd_ff.rd_len != 8'h00 && cmd_ff.len1 == 8'h00) ? DIR_READ : DIR_WRITE;
         case (cmd_ff.op) // [RULE_11]
            OP_XFER, OP_START: nxt_st = S_START;
            OP_RESTART: nxt_st = S_RESTART;
            OP_STOP: nxt_st = S_STOP;
            OP_SCL_PULSE: nxt_st = S_PULSE;
            OP_SDA_REL:
            begin
               nxt_sda = 1'h0;
               fin = 1'h1;
            end
            default:
            begin
               nxt_st  = S_IDLE;
               nxt_scl = 1'h0;
               nxt_sda = 1'h0;
               fin = 1'h1;
            end
         endcase
      end
      if (fin)
      begin
         nxt_st = S_IDLE;
         nxt_tgl[EV_DONE] = !tgl_ff[EV_DONE];
      end
   end

   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff      <= S_IDLE;
         ph_ff      <= 2'h0;
         q_ff       <= '0;
         bit_ff     <= 4'h0;
         sh_ff      <= 8'h00;
         smp_ff     <= 1'h1;
         e_ff       <= '0;
         dir_ff     <= DIR_WRITE;
         adr_ff     <= 1'h0;
         scl_drv_ff <= 1'h0;
         sda_drv_ff <= 1'h0;
         res_ff     <= RES_OK;
         tgl_ff     <= '0;
         rxb_ff     <= 8'h00;
      end
      else
      begin
         st_ff      <= nxt_st;
         ph_ff      <= nxt_ph;
         q_ff       <= nxt_q;
         bit_ff     <= nxt_bit;
         sh_ff      <= nxt_sh;
         smp_ff     <= nxt_smp;
         e_ff       <= nxt_e;
         dir_ff     <= nxt_dir;
         adr_ff     <= nxt_adr;
         scl_drv_ff <= nxt_scl;
         sda_drv_ff <= nxt_sda;
         res_ff     <= nxt_res;
         tgl_ff     <= nxt_tgl;
         rxb_ff     <= nxt_rxb;
      end
   end

   // open drain: drive low only
   assign scl_out  = 1'h0;
   assign sda_out  = 1'h0;
   assign scl_oe_n = !scl_drv_ff;
   assign sda_oe_n = !sda_drv_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_addr_dir: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_01]
      $rose(adr_ff) |-> sh_ff[0] == dir_ff)
      else $error("address byte direction bit wrong");
   a_read_ack: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_06]
      (st_ff == S_BYTE_R && bit_ff == 4'h8 && ph_ff == 2'h1)
      |-> sda_drv_ff == (e_ff.rd_len != 8'h01))
      else $error("read acknowledge level wrong");
   a_sda_hold: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_02]
      (st_ff == S_BYTE_W && ph_ff == 2'h2 && $past(ph_ff) == 2'h2) |-> $stable(sda_drv_ff))
      else $error("sda moved while scl high");
   a_nack_stop: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_15]
      $changed(tgl_ff[EV_NACK]) |-> (st_ff == S_STOP && res_ff == RES_NACK))
      else $error("nack not followed by stop");
   a_arb_release: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_14]
      $changed(tgl_ff[EV_ARB]) |-> (st_ff == S_IDLE && !scl_drv_ff && !sda_drv_ff))
      else $error("lines held after lost arbitration");
   a_done_stop: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_12]
      ($changed(tgl_ff[EV_DONE]) && e_ff.op == OP_XFER && res_ff != RES_ARB)
      |-> $changed(tgl_ff[EV_STOP]))
      else $error("transfer done without stop");
   a_start_cond: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE_09]
      (st_ff == S_START && ph_ff == 2'h2 && $past(ph_ff) == 2'h1)
      |-> (sda_drv_ff && !scl_drv_ff))
      else $error("start condition shape wrong");
   a_busy_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_10]
      (busy_ff && cmd_valid && cmd.op != OP_RESET && !l2c_p[EV_DONE])
      |=> ($stable(cmd_ff) && busy_ff))
      else $error("command taken during transaction");
endmodule // imt_sequencer
`default_nettype wire

// file: dv/imt_slave.sv
// behavioural i2c slave: acks its address and written bytes, serves read bytes
// assumes open-drain wires resolved by the bench with pull-ups
`timescale 1ns/1ps
`default_nettype none
module imt_slave
#(
   parameter logic [6:0] ADDR = 7'h52
)
(
   input  wire logic scl,
   input  wire logic sda,
   output logic      sda_low
);
   logic [7:0] sh, rd_b;
   logic [7:0] lg [16];
   logic       ma [16];
   logic       act, first, sel, rd, go, mack;
   int         bitc, n_lg, n_sp, ridx;
   initial {sda_low, act, first, sel, rd, go, mack, n_lg, n_sp, ridx, bitc} = '0;
   // start or restart
   always @(negedge sda) if (scl === 1'b1)
   begin
      act = 1; first = 1; bitc = -1; go = 0;
   end
   always @(posedge sda) if (scl === 1'b1 && act)
   begin
      act = 0; n_sp++;
   end
   always @(posedge scl) if (act)
   begin
      if (bitc >= 0 && bitc < 8) sh = {sh[6:0], sda};
      if (bitc == 8) mack = sda;
   end
   always @(negedge scl) if (act)
   begin
      bitc++;
      if (bitc == 8 && !go && n_lg < 16)
      begin
         lg[n_lg] = sh; n_lg++;
      end
      if (bitc == 8 && first)
      begin
         sel = sh[7:1] == ADDR; rd = sh[0];
      end
      if (bitc == 9)
      begin
         bitc = 0;
         if (go)
         begin
            ma[ridx] = mack; ridx++; go = !mack;
         end
         else if (first)
         begin
            go = sel && rd; ridx = 0;
         end
         first = 0;
      end
      rd_b = 8'hC3 ^ 8'(ridx);
      // read bits, else acknowledge slot
      sda_low = go ? (bitc < 8 && !rd_b[7-bitc]) : (bitc == 8 && sel && (first || !rd));
   end
endmodule // imt_slave
`default_nettype wire

// file: dv/tb.sv
// self-checking bench of the sequencer against the slave model
// assumes pull-ups on both bus lines; jam pulls sda low to force a lost start
`timescale 1ns/1ps
`default_nettype none
module tb;
   import imt_pkg::*;
   logic        clock, rst_n, link_clk, cmd_valid, tx_valid, jam, sl_low;
   logic        cmd_ready, tx_ready, rx_valid, done, busy;
   logic        scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic [7:0]  tx_data, rx_data;
   logic [7:0]  rx [8];
   imt_cmd_type cmd;
   imt_res_type result;
   imt_evt_type evt;
   int          mismatches, n_checks, nrx;
   int          ec [6];
   wire logic   scl = scl_oe_n;
   wire logic   sda = sda_oe_n & !sl_low & !jam;
   imt_sequencer #(.QCNT_W(8)) i_imt_sequencer (.clock, .rst_n, .link_clk, .cmd_valid,
      .cmd, .cmd_ready, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .done,
      .result, .busy, .evt, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out,
      .sda_oe_n);
   imt_slave i_imt_slave (.scl(scl), .sda(sda), .sda_low(sl_low));
   initial
   begin
      clock = 0;
      forever #12.5 clock = ~clock;
   end
   initial
   begin
      link_clk = 0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   // ----------------------------------------
   // monitors, byte source, checks, closing
   // ----------------------------------------
   always @(posedge clock)
   begin
      if (rx_valid && nrx < 8)
      begin
         rx[nrx] <= rx_data; nrx <= nrx + 1;
      end
      if (tx_valid && tx_ready) tx_data <= tx_data + 8'h01;
      // count real pulses only, so the per-run clear is never overwritten
      for (int k = 0; k < 6; k++)
         if (evt[k]) ec[k] <= ec[k] + 1;
   end
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task end_of_test;
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic run(imt_op_type op, logic [6:0] a, logic [7:0] l1, l2, rl, logic f,
                      imt_res_type er);
      logic [7:0] t0;
      int         nb, rr, i;
      t0 = tx_data;
      nb = (er != RES_OK || op != OP_XFER) ? 0 : (rl != 0) ? l1 : l1 + l2;
      rr = (l1 != 0 && rl != 0) ? 1 : 0;
      i_imt_slave.n_lg = 0;
      i_imt_slave.n_sp = 0;
      @(posedge clock);
      nrx <= 0;
      ec <= '{default: 0};
      cmd <= '{op, f, a, l1, l2, rl};
      cmd_valid <= 1'b1;
      tx_valid <= 1'b1;
      @(posedge clock);
      // second offer while busy, made for every op but reset, must be refused
      cmd_valid <= op != OP_RESET;
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1 chk("cmd_ready", 8'(cmd_ready), 8'(op == OP_RESET));
      chk("busy", 8'(busy), 8'h01);
      for (i = 0; i < 40000 && done !== 1'b1; i++)
      begin
         @(posedge clock);
         #1;
      end
      if (i == 40000)
      begin
         mismatches++;
         end_of_test;
      end
      chk("result", 8'(result), 8'(er));
      chk("idle_out", 8'({busy, scl_out, sda_out}), 8'h00);
      @(posedge clock);
      tx_valid <= 1'b0;
      // let the monitor count the closing pulses
      #1;
      if (op == OP_XFER)
      begin
         chk("stops", 8'(i_imt_slave.n_sp), er != RES_ARB);
         chk("ev_nack", 8'(ec[EV_NACK]), er == RES_NACK);
         chk("ev_arb", 8'(ec[EV_ARB]), er == RES_ARB);
         if (er == RES_OK)
         begin
            chk("addr", i_imt_slave.lg[0], {a, rl != 0 && l1 == 0});
            for (int k = 0; k < nb; k++)
               chk("wbyte", i_imt_slave.lg[k+1], t0 + 8'(k));
            if (rr != 0) chk("raddr", i_imt_slave.lg[nb+1], {a, 1'b1});
            chk("nlog", 8'(i_imt_slave.n_lg), 8'(1 + nb + rr));
            chk("ev_start", 8'(ec[EV_START] != 0), 8'h01);
            chk("ev_addr", 8'(ec[EV_ADDR]), 8'(1 + rr));
            chk("ev_data", 8'(ec[EV_DATA]), 8'(nb + rl));
            chk("ev_stop", 8'(ec[EV_STOP]), 8'h01);
            for (int k = 0; k < rl; k++)
            begin
               chk("rx", rx[k], 8'hC3 ^ 8'(k));
               chk("mack", i_imt_slave.ma[k], k == rl - 1);
            end
         end
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_two_buf; run(OP_XFER, 7'h52, 8'h02, 8'h03, 8'h00, 1'b1, RES_OK); endtask
   task t_second; run(OP_XFER, 7'h52, 8'h00, 8'h02, 8'h00, 1'b1, RES_OK); endtask
   // standard rate, address only
   task t_addr_only; run(OP_XFER, 7'h52, 8'h00, 8'h00, 8'h00, 1'b0, RES_OK); endtask
   task t_read; run(OP_XFER, 7'h52, 8'h00, 8'h00, 8'h03, 1'b1, RES_OK); endtask
   task t_wr_rd; run(OP_XFER, 7'h52, 8'h01, 8'h05, 8'h02, 1'b1, RES_OK); endtask
   task t_nack; run(OP_XFER, 7'h11, 8'h02, 8'h00, 8'h00, 1'b1, RES_NACK); endtask
   task t_arb;
      jam <= 1'b1;
      run(OP_XFER, 7'h52, 8'h01, 8'h00, 8'h00, 1'b1, RES_ARB);
      jam <= 1'b0;
   endtask
   task automatic t_recover;
      // sda release right after start, while the line is still held low
      imt_op_type ops [6] = '{OP_START, OP_SDA_REL, OP_RESTART, OP_STOP, OP_SCL_PULSE,
                              OP_RESET};
      for (int k = 0; k < 6; k++)
      begin
         run(ops[k], 7'h52, 8'h00, 8'h00, 8'h00, 1'b1, RES_OK);
         if (ops[k] == OP_SDA_REL) chk("sda_rel", 8'(sda), 8'h01);
         if (ops[k] == OP_SCL_PULSE) chk("scl_held", 8'(scl), 8'h00);
      end
      chk("released", 8'({scl, sda}), 8'h03);
   endtask
   initial
   begin
      {rst_n, cmd_valid, tx_valid, jam, nrx, mismatches, n_checks} = '0;
      cmd = '0;
      tx_data = 8'h10;
      ec = '{default: 0};
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      t_two_buf;
      t_second;
      t_addr_only;
      t_read;
      t_wr_rd;
      t_nack;
      t_arb;
      t_recover;
      end_of_test;
   end
endmodule // tb
`default_nettype wire
